/* File: inc/fbbp_pkg.sv */
// package of constants for the five-bit bidirectional port
package fbbp_pkg;

	// ****************************************************************
	// register map (printed offsets, not all multiples of four: index*4)
	// ****************************************************************
	localparam logic [7:0]  FBBP_IDX_PIN_DATA  = 8'h05;      // data register index
	localparam logic [7:0]  FBBP_IDX_DIRECTION = 8'h85;      // direction register index
	localparam logic [9:0]  FBBP_ADDR_PIN_DATA  = 10'h014;   // byte address = index * 4
	localparam logic [9:0]  FBBP_ADDR_DIRECTION = 10'h214;   // byte address = index * 4
	localparam logic [9:0]  FBBP_ADDR_BITOP     = 10'h300;   // bit set/clear command register
	localparam logic [9:0]  FBBP_ADDR_LATCH     = 10'h304;   // latch readback register

	// ****************************************************************
	// field layout and reset values
	// ****************************************************************
	localparam int          FBBP_WIDTH        = 5;           // implemented port bits
	localparam logic [4:0]  FBBP_DIR_RESET    = 5'h1F;       // all inputs after any reset
	localparam logic [4:0]  FBBP_LATCH_POR    = 5'h00;       // power-on latch value (undefined)
	localparam int          FBBP_OD_BIT       = 4;           // open-drain / timer clock bit
	localparam int          FBBP_BITOP_SET    = 3;           // bitop field: 1 = set, 0 = clear
	localparam logic [1:0]  FBBP_RESP_OKAY    = 2'h0;        // axi okay
	localparam logic [1:0]  FBBP_RESP_SLVERR  = 2'h2;        // axi slave error
	localparam int          FBBP_SYNC_STAGES  = 2;           // pin sampling stages

	// write sequencing states
	typedef enum logic [2:0]
	{
		FBBP_W_IDLE = 3'h1,
		FBBP_W_RESP = 3'h2,
		FBBP_W_HOLD = 3'h4
	} fbbp_wstate_t;

endpackage

/* File: hw/fbbp_pin_sampler.sv */
// pin input stage: no thresholding model, the same two-flop sampler for every bit
`timescale 1ns/1ps
module fbbp_pin_sampler
	import fbbp_pkg::*;
#(
	parameter int WIDTH = FBBP_WIDTH                 // number of pins
)
(
	input  wire logic             clock_in,          // system clock
	input  wire logic             rstn_in,           // async reset, active low
	input  wire logic [WIDTH-1:0] pad_in,            // raw pad levels
	output logic      [WIDTH-1:0] level_out          // sampled pin levels
);

	// ****************************************************************
	// sampling chain
	// ****************************************************************
	logic [WIDTH-1:0] stage1_reg;                    // first flop, read only by the second
	logic [WIDTH-1:0] level_reg;                     // settled level

	// thresholds are analog; here every pad is a clean digital level, and
	// the schmitt bit gets the same two-flop path as the ttl bits
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			stage1_reg <= '0;
			level_reg  <= '0;
		end
		else
		begin
			stage1_reg <= pad_in;
			level_reg  <= stage1_reg;
		end
	end

	assign level_out = level_reg;

endmodule

/* File: hw/fbbp_port.sv */
// five-bit bidirectional general-purpose port with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fbbp_port
	import fbbp_pkg::*;
#(
	parameter int WIDTH = FBBP_WIDTH                 // port width
)
(
	input  wire logic              clock_in,         // 50 mhz clock
	input  wire logic              rstn_in,          // async reset, active low
	input  wire logic              por_in,           // high when reset came from power-on
	// axi4-lite write address
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [11:0]       s_axi_awaddr_in,
	// axi4-lite write data
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	// axi4-lite write response
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	output logic [1:0]             s_axi_bresp_out,
	// axi4-lite read address
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	input  wire logic [11:0]       s_axi_araddr_in,
	// axi4-lite read data
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	// port pins
	input  wire logic [WIDTH-1:0]  port_pin_in,      // pad levels
	output logic      [WIDTH-1:0]  port_pin_out,     // pad output value
	output logic      [WIDTH-1:0]  port_pin_oe_out,  // high while driving
	output logic                   timer0_external_clock_out // sampled bit 4 level
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [WIDTH-1:0] latch_reg;                     // output latches
	logic [WIDTH-1:0] dir_reg;                       // direction, one = input
	logic [WIDTH-1:0] pin_level;                     // sampled pins
	fbbp_wstate_t     wstate_reg;                    // write sequencing
	logic             aw_got_reg;                    // address held
	logic             w_got_reg;                     // data held
	logic [11:0]      awaddr_reg;                    // captured write address
	logic [31:0]      wdata_reg;                     // captured write data
	logic             wstrb0_reg;                    // low byte lane enabled
	logic             por_seen_reg;                  // reset-release flag, high through any reset until the first edge after release

	// ****************************************************************
	// helpers
	// ****************************************************************
	// address compare used by both channels
	function automatic logic addr_is(input logic [11:0] a, input logic [9:0] reg_addr);
		addr_is = (a[11:10] == 2'h0) && (a[9:0] == reg_addr);
	endfunction

	// widen a port value to a bus word, upper bits zero
	function automatic logic [31:0] to_word(input logic [WIDTH-1:0] v);
		to_word = {{(32-WIDTH){1'b0}}, v};
	endfunction

	// ****************************************************************
	// pin input stage
	// ****************************************************************
	fbbp_pin_sampler #(
		.WIDTH     (WIDTH)
	) u_sampler (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.pad_in    (port_pin_in),
		.level_out (pin_level)
	);

	// ****************************************************************
	// write channel: take address and data in either order
	// ****************************************************************
	wire take_aw = s_axi_awvalid_in && s_axi_awready_out;
	wire take_w  = s_axi_wvalid_in && s_axi_wready_out;
	wire both_in = (aw_got_reg || take_aw) && (w_got_reg || take_w);

	// capture address and data; ready falls once each item is held
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_got_reg        <= 1'b0;
			w_got_reg         <= 1'b0;
			awaddr_reg        <= 12'h000;
			wdata_reg         <= 32'h00000000;
			wstrb0_reg        <= 1'b0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end
		else
		begin
			if (take_aw)
			begin
				awaddr_reg <= s_axi_awaddr_in;
			end
			if (take_w)
			begin
				wdata_reg  <= s_axi_wdata_in;
				wstrb0_reg <= s_axi_wstrb_in[0];
			end
			if (wstate_reg == FBBP_W_IDLE && both_in)
			begin
				// pair complete, hold both channels until response done
				aw_got_reg        <= 1'b0;
				w_got_reg         <= 1'b0;
				s_axi_awready_out <= 1'b0;
				s_axi_wready_out  <= 1'b0;
			end
			else if (wstate_reg == FBBP_W_IDLE)
			begin
				aw_got_reg        <= aw_got_reg || take_aw;
				w_got_reg         <= w_got_reg || take_w;
				s_axi_awready_out <= !(aw_got_reg || take_aw);
				s_axi_wready_out  <= !(w_got_reg || take_w);
			end
		end
	end

	// decode of the held write, declared ahead of the sequencer that reads it
	wire wr_data  = addr_is(awaddr_reg, FBBP_ADDR_PIN_DATA);
	wire wr_dir   = addr_is(awaddr_reg, FBBP_ADDR_DIRECTION);
	wire wr_bitop = addr_is(awaddr_reg, FBBP_ADDR_BITOP);
	wire wr_latch = addr_is(awaddr_reg, FBBP_ADDR_LATCH);
	wire wr_known = wr_data || wr_dir || wr_bitop || wr_latch;
	wire wr_go    = (wstate_reg == FBBP_W_RESP) && wstrb0_reg;

	// write sequencer: apply and respond at the same edge
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wstate_reg       <= FBBP_W_IDLE;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= FBBP_RESP_OKAY;
		end
		else
		begin
			case (wstate_reg)
				FBBP_W_IDLE:
				begin
					if (both_in)
					begin
						wstate_reg <= FBBP_W_RESP;
					end
				end
				FBBP_W_RESP:
				begin
					// latch update and answer both happen in this edge
					s_axi_bvalid_out <= 1'b1;
					s_axi_bresp_out  <= wr_known ? FBBP_RESP_OKAY : FBBP_RESP_SLVERR;
					wstate_reg       <= FBBP_W_HOLD;
				end
				FBBP_W_HOLD:
				begin
					if (s_axi_bready_in)
					begin
						s_axi_bvalid_out <= 1'b0;
						wstate_reg       <= FBBP_W_IDLE;
					end
				end
				default:
				begin
					wstate_reg <= FBBP_W_IDLE;
				end
			endcase
		end
	end

	// bit operation: pins read, one bit changed if its index is below five, whole word to latches
	logic [WIDTH-1:0] bitop_value;
	always_comb
	begin
		bitop_value = pin_level;
		if (wdata_reg[2:0] < 3'(WIDTH))
		begin
			bitop_value[wdata_reg[2:0]] = wdata_reg[FBBP_BITOP_SET];
		end
	end

	// ****************************************************************
	// output latches: kept on warm reset, never reset asynchronously
	// ****************************************************************
	always_ff @(posedge clock_in)
	begin
		if (por_seen_reg && por_in)
		begin
			// only a power-on release clears; warm resets keep the latches
			latch_reg <= FBBP_LATCH_POR;            // defined stand-in for unknown
		end
		else if (wr_go && wr_data)
		begin
			latch_reg <= wdata_reg[WIDTH-1:0];
		end
		else if (wr_go && wr_bitop)
		begin
			latch_reg <= bitop_value;
		end
	end

	// high for the first edge after any reset release; por_in tells which kind
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			por_seen_reg <= 1'b1;
		end
		else
		begin
			por_seen_reg <= 1'b0;
		end
	end

	// direction register returns to all inputs on every reset
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			dir_reg <= FBBP_DIR_RESET;
		end
		else if (wr_go && wr_dir)
		begin
			dir_reg <= wdata_reg[WIDTH-1:0];
		end
	end

	// ****************************************************************
	// pin drivers, registered
	// ****************************************************************
	// bit 4 is open drain: enable only when driving a zero
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			port_pin_out              <= '0;
			port_pin_oe_out           <= '0;
			timer0_external_clock_out <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < WIDTH; i++)
			begin
				if (i == FBBP_OD_BIT)
				begin
					port_pin_out[i]    <= 1'b0;
					port_pin_oe_out[i] <= !dir_reg[i] && !latch_reg[i];
				end
				else
				begin
					port_pin_out[i]    <= latch_reg[i];
					port_pin_oe_out[i] <= !dir_reg[i];
				end
			end
			timer0_external_clock_out <= pin_level[FBBP_OD_BIT];
		end
	end

	// ****************************************************************
	// read channel: one read at a time
	// ****************************************************************
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= FBBP_RESP_OKAY;
		end
		else if (s_axi_rvalid_out)
		begin
			if (s_axi_rready_in)
			begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= FBBP_RESP_OKAY;
			if (addr_is(s_axi_araddr_in, FBBP_ADDR_PIN_DATA))
			begin
				s_axi_rdata_out <= to_word(pin_level);
			end
			else if (addr_is(s_axi_araddr_in, FBBP_ADDR_DIRECTION))
			begin
				s_axi_rdata_out <= to_word(dir_reg);
			end
			else if (addr_is(s_axi_araddr_in, FBBP_ADDR_LATCH))
			begin
				s_axi_rdata_out <= to_word(latch_reg);
			end
			else if (addr_is(s_axi_araddr_in, FBBP_ADDR_BITOP))
			begin
				s_axi_rdata_out <= 32'h00000000;
			end
			else
			begin
				// unmapped: zero data, slave error
				s_axi_rdata_out <= 32'h00000000;
				s_axi_rresp_out <= FBBP_RESP_SLVERR;
			end
		end
		else
		begin
			s_axi_arready_out <= 1'b1;
		end
	end

endmodule

/* File: tb/fbbp_port_assertions.sv */
// checker of bus timing and pin rules of the five-bit port
`timescale 1ns/1ps
module fbbp_port_assertions
	import fbbp_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        rstn_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [4:0]  port_pin_in,
	input wire logic [4:0]  port_pin_out,
	input wire logic [4:0]  port_pin_oe_out,
	input wire logic        timer0_external_clock_out
);
	// ****************************************************************
	// one clock domain, so one default clock and reset
	// ****************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// both write channels taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// read address taken
	sequence s_rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	property p_wr_answer;
		s_wr_taken |-> !s_axi_bvalid_out ##2 s_axi_bvalid_out;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer not two edges after take");
	property p_rd_answer;
		s_rd_taken |=> s_axi_rvalid_out;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer not one edge after take");
	property p_b_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_upper_zero;
		s_axi_rvalid_out |-> s_axi_rdata_out[31:5] == 27'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("unimplemented bits read nonzero");
	property p_no_high;
		port_pin_oe_out[4] |-> port_pin_out[4] == 1'b0;
	endproperty
	a_no_high: assert property (p_no_high)
		else $error("open drain bit driven high");
	// sampler needs a few edges, so the pin must rest first
	property p_timer_clk;
		$stable(port_pin_in[4]) [*5] |-> timer0_external_clock_out == port_pin_in[4];
	endproperty
	a_timer_clk: assert property (p_timer_clk)
		else $error("timer clock not following pin 4");
	property p_dir_reset;
		!$past(rstn_in) |-> (port_pin_oe_out == 5'h00) [*3];
	endproperty
	a_dir_reset: assert property (p_dir_reset)
		else $error("pins driven right after reset");
endmodule

bind fbbp_port fbbp_port_assertions fbbp_port_assertions_inst (.clock_in, .rstn_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
	.port_pin_in, .port_pin_out, .port_pin_oe_out, .timer0_external_clock_out);

/* File: tb/fbbp_board.sv */
// board model: resolves the pad levels seen by the port
`timescale 1ns/1ps
module fbbp_board
	import fbbp_pkg::*;
(
	input  wire logic [4:0] pin_out_in,   // port output value
	input  wire logic [4:0] oe_in,        // port drive enables
	input  wire logic [4:0] ext_in,       // outside circuit level, bit 4 has no pull-up
	output logic      [4:0] pad_out       // resolved pad level
);
	// released pads fall back to the outside circuit, never to the old value
	always_comb
	begin
		for (int i = 0; i < FBBP_WIDTH; i++)
			pad_out[i] = oe_in[i] ? pin_out_in[i] : ext_in[i];
	end
endmodule

/* File: tb/fbbp_port_test.sv */
// self-checking bench for the five-bit port
`timescale 1ns/1ps
module fbbp_port_test
	import fbbp_pkg::*;
;
	logic        clk = 1'b0;            // 50 mhz clock
	logic        rstn = 1'b0;           // reset, active low
	logic        por = 1'b1;            // power-on indication, low for warm resets
	logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0]  ws = 4'hF;             // write strobes
	logic [4:0]  ext = 5'h1F;           // outside circuit levels
	logic        awr, wre, bv, arr, rv, tclk;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rd, got;
	logic [4:0]  pad, pout, oe;
	int          n_fail = 0, n_compared = 0;

	always #10 clk = ~clk;

	fbbp_port fbbp_port_inst (.clock_in(clk), .rstn_in(rstn), .por_in(por),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wre), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .port_pin_in(pad),
		.port_pin_out(pout), .port_pin_oe_out(oe), .timer0_external_clock_out(tclk));
	fbbp_board fbbp_board_inst (.pin_out_in(pout), .oe_in(oe), .ext_in(ext), .pad_out(pad));

	// ****************************************************************
	// compare, bus and closing tasks
	// ****************************************************************
	task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// both channels offered together, each dropped once taken
	// bready comes late so the response must stand one unanswered cycle
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wre)
				wv <= 1'b0;
		end
		while (!bv);
		bre <= 1'b1;
		do
			@(posedge clk);
		while (!bv);
		r = bresp;
		bre <= 1'b0;
	endtask
	// rready also comes late, so read data must stand unanswered once
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		do
			@(posedge clk);
		while (!arr);
		arv <= 1'b0;
		do
			@(posedge clk);
		while (!rv);
		rre <= 1'b1;
		do
			@(posedge clk);
		while (!rv);
		d = rd;
		r = rresp;
		rre <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
		axi_rd(a, got, rsp);
		chk_data(nm, e, got);
		chk_resp(nm, FBBP_RESP_OKAY, rsp);
	endtask
	task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		chk_resp("bresp", FBBP_RESP_OKAY, rsp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog: the tests need under two hundred cycles
	initial
	begin
		repeat (4000) @(posedge clk);
		n_fail++;
		end_sim();
	end

	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(FBBP_ADDR_DIRECTION, 32'h1F, "direction");
		rd_chk(FBBP_ADDR_LATCH, {27'h0, FBBP_LATCH_POR}, "latch power-on");
		por <= 1'b0;
		chk_data("oe after reset", 32'h0, {27'h0, oe});
		ext <= 5'h0A;
		idle(4);
		rd_chk(FBBP_ADDR_PIN_DATA, 32'h0A, "pins");
		wr_ok(FBBP_ADDR_PIN_DATA, 32'hFFFFFF15);
		rd_chk(FBBP_ADDR_LATCH, 32'h15, "latch");
		rd_chk(FBBP_ADDR_PIN_DATA, 32'h0A, "pins not latch");
		ws <= 4'h0;
		wr_ok(FBBP_ADDR_PIN_DATA, 32'h0);
		ws <= 4'hF;
		rd_chk(FBBP_ADDR_LATCH, 32'h15, "latch kept");
		wr_ok(FBBP_ADDR_DIRECTION, 32'hFFFFFF00);
		idle(4);
		chk_data("pin out", 32'h05, {27'h0, pout});
		chk_data("oe", 32'h0F, {27'h0, oe});
		rd_chk(FBBP_ADDR_PIN_DATA, 32'h05, "driven pins");
		rd_chk(FBBP_ADDR_DIRECTION, 32'h00, "direction");
		// mixed port: pins copied into input latches
		wr_ok(FBBP_ADDR_DIRECTION, 32'hFFFFFFFC);
		ext <= 5'h18;
		idle(4);
		wr_ok(FBBP_ADDR_BITOP, 32'h9);
		rd_chk(FBBP_ADDR_LATCH, 32'h1B, "set bit");
		idle(4);
		wr_ok(FBBP_ADDR_BITOP, 32'h0);
		rd_chk(FBBP_ADDR_LATCH, 32'h1A, "clear bit");
		ext <= 5'h04;
		idle(4);
		wr_ok(FBBP_ADDR_BITOP, 32'hF);
		rd_chk(FBBP_ADDR_LATCH, 32'h06, "index out of range");
		// unmapped address
		axi_rd(12'h008, got, rsp);
		chk_data("unmapped read", 32'h0, got);
		chk_resp("unmapped read", FBBP_RESP_SLVERR, rsp);
		axi_wr(12'h008, 32'h1, rsp);
		chk_resp("unmapped write", FBBP_RESP_SLVERR, rsp);
		// timer clock and open drain on bit 4
		ext <= 5'h10;
		idle(6);
		chk_data("timer clock", 32'h1, {31'h0, tclk});
		wr_ok(FBBP_ADDR_DIRECTION, 32'h0);
		idle(6);
		chk_data("oe all", 32'h1F, {27'h0, oe});
		chk_data("drive low", 32'h0, {31'h0, tclk});
		// warm reset mid-run: direction returns to inputs, latches stay
		rstn <= 1'b0;
		idle(2);
		rstn <= 1'b1;
		rd_chk(FBBP_ADDR_DIRECTION, 32'h1F, "direction warm");
		rd_chk(FBBP_ADDR_LATCH, 32'h06, "latch warm");
		chk_data("oe warm", 32'h0, {27'h0, oe});
		end_sim();
	end
endmodule
